// ---- rtl/legacy_adapter_mode_regs.sv ----
`timescale 1ns/1ns
`include "legacy_adapter_params.svh"
module legacy_adapter_mode_regs (
  input wire logic core_clk, // 100 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic [15:0] io_addr, // I/O port address
  input wire logic [7:0] io_wdata, // I/O write data
  input wire logic io_wr, // I/O write strobe, one cycle
  input wire logic io_rd, // I/O read strobe, one cycle
  output logic [7:0] io_rdata, // Read data, always zero
  output logic io_rd_claim, // Never claims a read
  input wire logic crtc_emul, // Legacy controller emulation active
  output logic mono_hires, // High resolution enabled
  output logic mono_video_en, // Mono video enabled
  output logic mono_blink_en, // Mono character blink
  output logic mono_gfx, // Mono graphics display
  output logic mono_upper_page, // Upper page accessible
  output logic mono_page_b800, // Display base at B800
  output logic color_blink_en, // Colour blink enabled
  output logic color_video_en, // Colour video enabled
  output logic color_en, // Colour rather than monochrome
  output logic text_80col, // 80 columns rather than 40
  output legacy_adapter_pkg::video_fmt_t color_fmt, // Picture format
  output legacy_adapter_pkg::rgbi_t border_rgbi, // Border colour
  output legacy_adapter_pkg::rgbi_t background_rgbi, // Background colour
  output legacy_adapter_pkg::rgbi_t foreground_rgbi, // 640 mode foreground
  output logic palette_sel, // 320 mode palette choice
  output logic alt_color_set, // Alternate set in graphics
  output logic alpha_bg_sel // Background bit in alpha mode
);
  import legacy_adapter_pkg::*;

  mode_regs_if rif ();

  reg_byte_t mono_mc_q;
  logic [1:0] mono_gm_q;
  reg_byte_t color_mode_q;
  reg_byte_t color_sel_q;
  logic wr_mc;
  logic wr_gm;
  logic wr_cm;
  logic wr_cs;

  // Exact 16-bit match; no aliasing of the legacy ports
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    port_hit = (addr == port);
  endfunction

  // Write strobes per port
  assign wr_mc = io_wr & port_hit(io_addr, `PORT_MONO_MODE_CONTROL);
  assign wr_gm = io_wr & port_hit(io_addr, `PORT_MONO_GRAPHICS_MODE);
  assign wr_cm = io_wr & port_hit(io_addr, `PORT_COLOR_ADAPTER_MODE);
  assign wr_cs = io_wr & port_hit(io_addr, `PORT_COLOR_SELECT);

  // Mono mode-control register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      mono_mc_q <= `RST_BYTE;
    else if (wr_mc)
      mono_mc_q <= io_wdata;
  end

  // Registers change only when their own port is written
  AST_MC_STORE: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_mc |=> (mono_mc_q == $past(io_wdata)))
    else $error("mode control byte not stored");

  AST_MC_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !wr_mc |=> $stable(mono_mc_q))
    else $error("mode control changed without a write");

  // Mono graphics-mode register; only two bits exist
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      mono_gm_q <= `RST_GFX;
    else if (wr_gm)
      mono_gm_q <= io_wdata[1:0] & {2{mono_mc_q[`MC_GFX_EN]}};
  end

  AST_GM_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !wr_gm |=> $stable(mono_gm_q))
    else $error("graphics mode changed without a write");

  // Colour adapter mode register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      color_mode_q <= `RST_BYTE;
    else if (wr_cm)
      color_mode_q <= io_wdata;
  end

  AST_CM_STORE: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_cm |=> (color_mode_q == $past(io_wdata)))
    else $error("colour mode byte not stored");

  AST_CM_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !wr_cm |=> $stable(color_mode_q))
    else $error("colour mode changed without a write");

  // Colour select register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      color_sel_q <= `RST_BYTE;
    else if (wr_cs)
      color_sel_q <= io_wdata;
  end

  AST_CS_STORE: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_cs |=> (color_sel_q == $past(io_wdata)))
    else $error("colour select byte not stored");

  AST_CS_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !wr_cs |=> $stable(color_sel_q))
    else $error("colour select changed without a write");

  // Hand register contents to the decoders
  assign rif.mono_mc = mono_mc_q;
  assign rif.mono_gm = mono_gm_q;
  assign rif.color_mode = color_mode_q;
  assign rif.color_sel = color_sel_q;
  assign rif.crtc_emul = crtc_emul;

  mono_mode_decode u_mono (
    .rif(rif.mono)
  );

  color_mode_decode u_color (
    .rif(rif.color)
  );

  // Mono outputs, one cycle behind the register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mono_hires <= 1'b0;
      mono_video_en <= 1'b0;
      mono_blink_en <= 1'b0;
      mono_gfx <= 1'b0;
      mono_upper_page <= 1'b0;
      mono_page_b800 <= 1'b0;
    end
    else
    begin
      mono_hires <= mono_mc_q[`MC_HIRES];
      mono_video_en <= mono_mc_q[`MC_VIDEO];
      mono_blink_en <= mono_mc_q[`MC_BLINK];
      mono_gfx <= rif.mono_gfx;
      mono_upper_page <= rif.mono_upper;
      mono_page_b800 <= rif.mono_page_b800;
    end
  end

  // Colour mode outputs
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      color_blink_en <= 1'b0;
      color_video_en <= 1'b0;
      color_en <= 1'b0;
      text_80col <= 1'b0;
      color_fmt <= FMT_TEXT;
    end
    else
    begin
      color_blink_en <= color_mode_q[`CM_BLINK];
      color_video_en <= color_mode_q[`CM_VIDEO];
      color_en <= color_mode_q[`CM_COLOR];
      text_80col <= color_mode_q[`CM_80COL];
      color_fmt <= rif.fmt;
    end
  end

  // Colour select outputs
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      border_rgbi <= 4'h0;
      background_rgbi <= 4'h0;
      foreground_rgbi <= 4'h0;
      palette_sel <= 1'b0;
      alt_color_set <= 1'b0;
      alpha_bg_sel <= 1'b0;
    end
    else
    begin
      border_rgbi <= rif.border;
      background_rgbi <= rif.background;
      foreground_rgbi <= rif.foreground;
      palette_sel <= rif.palette;
      alt_color_set <= rif.alt_set;
      alpha_bg_sel <= rif.alpha_bg;
    end
  end

  // Write-only ports: reads are left for another agent to answer
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      io_rdata <= 8'h00;
    else
      io_rdata <= 8'h00;
  end
  assign io_rd_claim = 1'b0;

  // Registered page select follows the written page bit
  AST_PAGE_SELECT: assert property (@(posedge core_clk) disable iff (!resetn)
    (mono_mc_q[`MC_GFX_EN] && mono_gm_q[`GM_GFX] && crtc_emul) |=>
      (mono_page_b800 == $past(mono_mc_q[`MC_PAGE])))
    else $error("page select does not follow mode bit 7");

  AST_PAGE_TEXT: assert property (@(posedge core_clk) disable iff (!resetn)
    !mono_mc_q[`MC_GFX_EN] |=> !mono_page_b800)
    else $error("page select active without graphics enable");

  AST_MONO_BLINK: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_mc |=> ##1 (mono_blink_en == $past(io_wdata[`MC_BLINK], 2)))
    else $error("mono blink does not follow written bit");

  AST_GFX_BLOCKED: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_gm && !mono_mc_q[`MC_GFX_EN] && !wr_mc) |=> (mono_gm_q == 2'h0))
    else $error("graphics bits set while blocked");

  AST_GFX_ALLOWED: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_gm && mono_mc_q[`MC_GFX_EN]) |=> (mono_gm_q == $past(io_wdata[1:0])))
    else $error("graphics bits not stored while allowed");

  AST_FORCE_ALPHA: assert property (@(posedge core_clk) disable iff (!resetn)
    !mono_mc_q[`MC_GFX_EN] |=> (!mono_gfx && !mono_upper_page))
    else $error("alpha operation not forced");

  AST_HIRES: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_mc |=> ##1 (mono_hires == $past(io_wdata[`MC_HIRES], 2)))
    else $error("high resolution does not follow bit 0");

  AST_EMUL_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
    !crtc_emul |=> (!mono_gfx && !mono_upper_page && !mono_page_b800))
    else $error("graphics register active outside emulation");

  AST_UPPER_PAGE: assert property (@(posedge core_clk) disable iff (!resetn)
    (crtc_emul && mono_mc_q[`MC_GFX_EN]) |=> (mono_upper_page == $past(mono_gm_q[`GM_UPPER])))
    else $error("upper page map wrong");

  AST_GFX_SELECT: assert property (@(posedge core_clk) disable iff (!resetn)
    (crtc_emul && mono_mc_q[`MC_GFX_EN]) |=> (mono_gfx == $past(mono_gm_q[`GM_GFX])))
    else $error("graphics select wrong");

  AST_HIGH_BITS_IGNORED: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_gm && mono_mc_q[`MC_GFX_EN] && (io_wdata[1:0] == 2'h0)) |=> (mono_gm_q == 2'h0))
    else $error("upper graphics bits had an effect");

  AST_COLOR_BLINK: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_cm |=> ##1 (color_blink_en == $past(io_wdata[`CM_BLINK], 2)))
    else $error("colour blink does not follow bit 5");

  AST_FMT_640: assert property (@(posedge core_clk) disable iff (!resetn)
    color_mode_q[`CM_GFX640] |=> (color_fmt == FMT_GFX640))
    else $error("640 mode not selected");

  AST_VIDEO: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(color_mode_q[`CM_VIDEO]) |=> (color_video_en == $past(color_mode_q[`CM_VIDEO])))
    else $error("video enable does not follow bit 3");

  AST_COLOR_EN: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_cm |=> ##1 (color_en == $past(io_wdata[`CM_COLOR], 2)))
    else $error("colour enable does not follow bit 2");

  AST_FMT_320: assert property (@(posedge core_clk) disable iff (!resetn)
    (color_mode_q[`CM_GFX320] && !color_mode_q[`CM_GFX640]) |=> (color_fmt == FMT_GFX320))
    else $error("320 mode not selected");

  AST_80COL: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_cm |=> ##1 (text_80col == $past(io_wdata[`CM_80COL], 2)))
    else $error("column format wrong");

  AST_PALETTE: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_GFX320) |=> (palette_sel == $past(color_sel_q[`CS_PALETTE])))
    else $error("palette select wrong");

  AST_ALT_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_TEXT) |=> (!alt_color_set && alpha_bg_sel == $past(color_sel_q[`CS_ALT])))
    else $error("alternate set or alpha background wrong");

  AST_BORDER_TEXT: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt != FMT_GFX640) |=> (border_rgbi == $past(color_sel_q[3:0])))
    else $error("border colour wrong");

  AST_RED_FG: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_GFX640) |=>
      (foreground_rgbi[2] == ($past(color_sel_q[`CS_RED]) | $past(color_sel_q[`CS_INTENS]))))
    else $error("red foreground wrong");

  AST_GREEN_BG: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt != FMT_TEXT) |=> (background_rgbi[1] == $past(color_sel_q[`CS_GREEN])))
    else $error("green background wrong");

  AST_BLUE: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_GFX640) |=> (foreground_rgbi[0] == $past(color_sel_q[`CS_BLUE])))
    else $error("blue foreground wrong");

  AST_NO_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    io_rd |-> ##1 (io_rdata == 8'h00 && !io_rd_claim))
    else $error("write-only register returned data");

  // Page bit is ignored while alpha display is in force
  AST_OVERRIDE_PAGE: assert property (@(posedge core_clk) disable iff (!resetn)
    !mono_gm_q[`GM_GFX] |=> !mono_page_b800)
    else $error("page select active in alpha mode");

  // Decoded colour format and outputs, checked inside their format and quiet outside it
  AST_FMT_TEXT: assert property (@(posedge core_clk) disable iff (!resetn)
    (!color_mode_q[`CM_GFX640] && !color_mode_q[`CM_GFX320]) |=> (color_fmt == FMT_TEXT))
    else $error("text format not selected");

  AST_TEXT_NO_BG: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_TEXT) |=> (background_rgbi == 4'h0))
    else $error("background driven in text mode");

  AST_BG_320: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_GFX320) |=> (background_rgbi == $past(color_sel_q[3:0])))
    else $error("320 mode background wrong");

  AST_BORDER_640: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_GFX640) |=> (border_rgbi == 4'h0))
    else $error("border driven in 640 mode");

  AST_PALETTE_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt != FMT_GFX320) |=> !palette_sel)
    else $error("palette select outside 320 mode");

  AST_ALT_GFX: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt != FMT_TEXT) |=> (alt_color_set == $past(color_sel_q[`CS_ALT]) && !alpha_bg_sel))
    else $error("alternate set wrong in graphics");

  AST_FG_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt != FMT_GFX640) |=> (foreground_rgbi == 4'h0))
    else $error("foreground driven outside 640 mode");

  AST_FG_640_UNUSED: assert property (@(posedge core_clk) disable iff (!resetn)
    (rif.fmt == FMT_GFX640) |=> (!foreground_rgbi[3] && !foreground_rgbi[1]))
    else $error("unused foreground bits set in 640 mode");
endmodule

// ---- rtl/legacy_adapter_params.svh ----
`ifndef LEGACY_ADAPTER_PARAMS_SVH
`define LEGACY_ADAPTER_PARAMS_SVH
// I/O port addresses
`define PORT_MONO_MODE_CONTROL 16'h03b8
`define PORT_MONO_GRAPHICS_MODE 16'h03bf
`define PORT_COLOR_ADAPTER_MODE 16'h03d8
`define PORT_COLOR_SELECT 16'h03d9
// Reset values
`define RST_BYTE 8'h00
`define RST_GFX 2'h0
// Mono mode-control fields
`define MC_HIRES 0
`define MC_GFX_EN 1
`define MC_VIDEO 3
`define MC_BLINK 5
`define MC_PAGE 7
// Mono graphics-mode fields
`define GM_GFX 0
`define GM_UPPER 1
// Colour mode fields
`define CM_80COL 0
`define CM_GFX320 1
`define CM_COLOR 2
`define CM_VIDEO 3
`define CM_GFX640 4
`define CM_BLINK 5
// Colour select fields
`define CS_BLUE 0
`define CS_GREEN 1
`define CS_RED 2
`define CS_INTENS 3
`define CS_ALT 4
`define CS_PALETTE 5
`endif

// ---- rtl/legacy_adapter_pkg.sv ----
package legacy_adapter_pkg;
  // Picture format chosen by the colour mode register
  typedef enum logic [1:0] {FMT_TEXT, FMT_GFX320, FMT_GFX640} video_fmt_t;
  // Colour nibble ordered intensity, red, green, blue
  typedef logic [3:0] rgbi_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// ---- rtl/mode_regs_if.sv ----
`timescale 1ns/1ns
interface mode_regs_if;
  import legacy_adapter_pkg::*;
  reg_byte_t mono_mc;
  logic [1:0] mono_gm;
  reg_byte_t color_mode;
  reg_byte_t color_sel;
  logic crtc_emul;
  logic mono_gfx;
  logic mono_upper;
  logic mono_page_b800;
  video_fmt_t fmt;
  rgbi_t border;
  rgbi_t background;
  rgbi_t foreground;
  logic alt_set;
  logic alpha_bg;
  logic palette;
  modport regs (output mono_mc, mono_gm, color_mode, color_sel, crtc_emul,
    input mono_gfx, mono_upper, mono_page_b800, fmt, border, background, foreground,
    alt_set, alpha_bg, palette);
  modport mono (input mono_mc, mono_gm, crtc_emul,
    output mono_gfx, mono_upper, mono_page_b800);
  modport color (input color_mode, color_sel,
    output fmt, border, background, foreground, alt_set, alpha_bg, palette);
endinterface

// ---- rtl/mono_mode_decode.sv ----
`timescale 1ns/1ns
`include "legacy_adapter_params.svh"
module mono_mode_decode (
  mode_regs_if.mono rif // Register view and mono decodes
);
  import legacy_adapter_pkg::*;
  logic [1:0] gm_eff;
  // Emulation gate and mode-control override on both graphics bits
  assign gm_eff = rif.crtc_emul ? (rif.mono_gm & {2{rif.mono_mc[`MC_GFX_EN]}}) : 2'h0;
  assign rif.mono_gfx = gm_eff[`GM_GFX];
  assign rif.mono_upper = gm_eff[`GM_UPPER];
  // Page bit only counts in graphics emulation
  assign rif.mono_page_b800 = gm_eff[`GM_GFX] & rif.mono_mc[`MC_PAGE];
endmodule

// ---- rtl/color_mode_decode.sv ----
`timescale 1ns/1ns
`include "legacy_adapter_params.svh"
module color_mode_decode (
  mode_regs_if.color rif // Register view and colour decodes
);
  import legacy_adapter_pkg::*;
  logic [7:0] cs;
  assign cs = rif.color_sel;
  // 640 mode wins over 320 when software sets both
  always_comb
  begin
    if (rif.color_mode[`CM_GFX640])
      rif.fmt = FMT_GFX640;
    else if (rif.color_mode[`CM_GFX320])
      rif.fmt = FMT_GFX320;
    else
      rif.fmt = FMT_TEXT;
  end
  // Border in text and 320, background green only in 640
  always_comb
  begin
    rif.border = 4'h0;
    rif.background = 4'h0;
    rif.foreground = 4'h0;
    unique case (rif.fmt)
      FMT_TEXT: rif.border = cs[3:0];
      FMT_GFX320:
      begin
        rif.border = cs[3:0];
        rif.background = cs[3:0];
      end
      FMT_GFX640:
      begin
        rif.background = {2'h0, cs[`CS_GREEN], 1'b0};
        rif.foreground = {1'b0, cs[`CS_INTENS] | cs[`CS_RED], 1'b0, cs[`CS_BLUE]};
      end
      default: rif.border = 4'h0;
    endcase
  end
  assign rif.alt_set = (rif.fmt != FMT_TEXT) & cs[`CS_ALT];
  assign rif.alpha_bg = (rif.fmt == FMT_TEXT) & cs[`CS_ALT];
  assign rif.palette = (rif.fmt == FMT_GFX320) & cs[`CS_PALETTE];
endmodule

// ---- test/legacy_adapter_mode_regs_bench.sv ----
`timescale 1ns/1ns
`include "legacy_adapter_params.svh"
module legacy_adapter_mode_regs_bench;
  import legacy_adapter_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic crtc_emul = 1'b0;
  logic [7:0] io_rdata;
  logic io_rd_claim;
  logic mono_hires, mono_video_en, mono_blink_en, mono_gfx, mono_upper_page, mono_page_b800;
  logic color_blink_en, color_video_en, color_en, text_80col, palette_sel;
  logic alt_color_set, alpha_bg_sel;
  video_fmt_t color_fmt;
  rgbi_t border_rgbi, background_rgbi, foreground_rgbi;
  logic [7:0] mono_v, cmode_v, csel_a, csel_b;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] sel_tbl [13];

  // Output groups packed for compact comparison
  assign mono_v = {2'h0, mono_hires, mono_video_en, mono_blink_en, mono_gfx, mono_upper_page,
    mono_page_b800};
  assign cmode_v = {2'h0, color_blink_en, color_video_en, color_en, text_80col, 2'(color_fmt)};
  assign csel_a = {border_rgbi, background_rgbi};
  assign csel_b = {foreground_rgbi, 1'b0, palette_sel, alt_color_set, alpha_bg_sel};

  legacy_adapter_mode_regs dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .io_addr(io_addr),
    .io_wdata(io_wdata),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_rdata(io_rdata),
    .io_rd_claim(io_rd_claim),
    .crtc_emul(crtc_emul),
    .mono_hires(mono_hires),
    .mono_video_en(mono_video_en),
    .mono_blink_en(mono_blink_en),
    .mono_gfx(mono_gfx),
    .mono_upper_page(mono_upper_page),
    .mono_page_b800(mono_page_b800),
    .color_blink_en(color_blink_en),
    .color_video_en(color_video_en),
    .color_en(color_en),
    .text_80col(text_80col),
    .color_fmt(color_fmt),
    .border_rgbi(border_rgbi),
    .background_rgbi(background_rgbi),
    .foreground_rgbi(foreground_rgbi),
    .palette_sel(palette_sel),
    .alt_color_set(alt_color_set),
    .alpha_bg_sel(alpha_bg_sel)
  );

  // Free running 100 MHz clock
  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One write, strobe dropped after the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
  endtask

  // Outputs follow the register one edge later
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask

  // Outputs are only defined once a clock edge has seen reset low
  task automatic apply_reset;
    resetn = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    chk(mono_v | cmode_v | csel_a | csel_b, 8'h00, "outputs in reset");
    resetn = 1'b1;
  endtask

  // Reads are never answered, checked after a write to the same port
  task automatic t_read;
    wr(`PORT_COLOR_SELECT, 8'h3f);
    @(posedge core_clk);
    #1;
    io_addr = `PORT_COLOR_SELECT;
    io_rd = 1'b1;
    @(posedge core_clk);
    #1;
    chk(io_rdata, 8'h00, "read data");
    chk({7'h0, io_rd_claim}, 8'h00, "read claim");
    io_rd = 1'b0;
  endtask

  // Graphics bits refused while the enable bit is clear
  task automatic t_mono_blocked;
    crtc_emul = 1'b1;
    wr(`PORT_MONO_MODE_CONTROL, 8'h29);
    wr(`PORT_MONO_GRAPHICS_MODE, 8'h03);
    settle();
    chk(mono_v, 8'h38, "mono blocked");
    wr(`PORT_MONO_MODE_CONTROL, 8'hab);
    settle();
    chk(mono_v, 8'h38, "mono stored zero");
    wr(16'h03b9, 8'hff);
    settle();
    chk(mono_v, 8'h38, "unmapped port");
  endtask

  // Page, upper page and graphics under the override
  task automatic t_mono_graphics;
    wr(`PORT_MONO_GRAPHICS_MODE, 8'hfd);
    settle();
    chk(mono_v, 8'h3d, "mono gfx b800");
    wr(`PORT_MONO_GRAPHICS_MODE, 8'hfc);
    settle();
    chk(mono_v, 8'h38, "upper bits only");
    wr(`PORT_MONO_GRAPHICS_MODE, 8'h02);
    settle();
    chk(mono_v, 8'h3a, "mono upper page");
    wr(`PORT_MONO_GRAPHICS_MODE, 8'h03);
    wr(`PORT_MONO_MODE_CONTROL, 8'h23);
    settle();
    chk(mono_v, 8'h2e, "mono b000 page");
    crtc_emul = 1'b0;
    settle();
    chk(mono_v, 8'h28, "emulation off");
    crtc_emul = 1'b1;
    settle();
    chk(mono_v, 8'h2e, "emulation on");
    wr(`PORT_MONO_MODE_CONTROL, 8'h00);
    settle();
    chk(mono_v, 8'h00, "override clears");
  endtask

  // Colour mode bits, including both graphics bits and reserved bits
  task automatic t_color_mode;
    logic [7:0] mv [6] = '{8'h2d, 8'h02, 8'h12, 8'h0a, 8'h24, 8'hc1};
    logic [7:0] ev [6] = '{8'h3c, 8'h01, 8'h02, 8'h11, 8'h28, 8'h04};
    for (int i = 0; i < 6; i++)
    begin
      wr(`PORT_COLOR_ADAPTER_MODE, mv[i]);
      settle();
      chk(cmode_v, ev[i], "colour mode");
    end
  endtask

  // Colour select in text, 320 and 640 formats: mode, select, colours, flags
  task automatic t_color_select;
    sel_tbl = '{32'h003ff001, 32'h00055000, 32'h023fff06, 32'h020aaa00, 32'h02d00002,
      32'h103f0252, 32'h10080040, 32'h10040040, 32'h10010010, 32'h10020200,
      32'h10200000, 32'h02200004, 32'h00200000};
    for (int i = 0; i < 13; i++)
    begin
      wr(`PORT_COLOR_ADAPTER_MODE, sel_tbl[i][31:24]);
      wr(`PORT_COLOR_SELECT, sel_tbl[i][23:16]);
      settle();
      chk(csel_a, sel_tbl[i][15:8], "border and background");
      chk(csel_b, sel_tbl[i][7:0], "foreground and sets");
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence, with a second reset just before the final report
  initial
  begin
    apply_reset();
    settle();
    chk(mono_v | cmode_v | csel_a | csel_b, 8'h00, "after reset");
    t_read();
    t_mono_blocked();
    t_mono_graphics();
    t_color_mode();
    t_color_select();
    wr(`PORT_COLOR_ADAPTER_MODE, 8'h3f);
    settle();
    chk(cmode_v, 8'h3e, "before second reset");
    apply_reset();
    settle();
    chk(mono_v | cmode_v | csel_a | csel_b, 8'h00, "second reset");
    final_report();
  end

  // Guard against a hung run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    final_report();
  end
endmodule
